//--- dpm_pkg.sv
// Package for the dual port mailbox block: widths, reset values, port controls.
// Assumes one system clock; both port clocks arrive as ordinary sampled inputs.
package dpm_pkg;

  // ********************************************************
  // Widths and reset values
  // ********************************************************
  localparam int          DPM_DATA_W      = 36;
  localparam logic        DPM_FULL_N_RST  = 1'h1;        // No mail pending
  localparam logic [35:0] DPM_MAIL_RST    = 36'h0_0000_0000;
  localparam logic        DPM_CLK_Q_RST   = 1'h1;        // Blocks a false edge at release

  // ********************************************************
  // Port control group as sampled on a port clock edge
  // ********************************************************
  typedef struct packed {
    logic chip_select_n;  // Active low
    logic write;          // High selects a write on this port
    logic enable;         // Transfer enable
    logic mail_select;    // High steers to mailbox, low to FIFO
  } dpm_port_ctrl_type;

endpackage : dpm_pkg

//--- dpm_mailbox.sv
// Two 36-bit mailboxes between port A and port B with active-low full flags.
// Assumes port clocks and controls are synchronous to clk_i and sampled by it;
// clk_i must run well above both port clocks so every port edge is seen.
// Limitation: each port clock must stay low and high for at least one clk_i
// cycle, or its edge is missed and the transfer is silently lost.
// Trade-off: sampling the port clocks keeps one clock domain and no
// synchronisers, at the price of a fast system clock.
//
// Functional notes
// (R1) Two independent 36-bit mailboxes: A-to-B and B-to-A.
// (R2) Mail select high steers a transfer to mailbox, low to FIFO path.
// (R3) Port A mail write on its clock edge stores port A bus in A-to-B.
// (R4) Port B mail write on its clock edge stores port B bus in B-to-A.
// (R5) Accepted write drives that mailbox full flag low.
// (R6) Writes while full flag low are ignored; contents unchanged.
// (R7) Port B outputs show FIFO data if select low, A-to-B mailbox if high.
// (R8) Port A outputs always show the B-to-A mailbox when enabled.
// (R9) Port B mail read on its edge sets A-to-B full flag high.
// (R10) Port A mail read on its edge sets B-to-A full flag high.
// (R11) Reading never alters a mailbox; only accepted writes change it.
// (R12) In depth expansion both mail selects are held low externally.
// (R13) After reset both full flags are high so first write is taken.
// (R14) Flag set low by writer edge, high by reader edge, crossing safely.
`timescale 1ns/1ps
module dpm_mailbox
  import dpm_pkg::*;
(
  // System
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Port A pins
  input  wire logic                  porta_clock_i,
  input  wire dpm_port_ctrl_type     porta_ctrl_i,
  input  wire logic [DPM_DATA_W-1:0] porta_data_bus_i,
  output logic      [DPM_DATA_W-1:0] porta_data_bus_o,
  output logic                       porta_data_bus_oe_o,
  // Port B pins
  input  wire logic                  portb_clock_i,
  input  wire dpm_port_ctrl_type     portb_ctrl_i,
  input  wire logic [DPM_DATA_W-1:0] portb_data_bus_i,
  output logic      [DPM_DATA_W-1:0] portb_data_bus_o,
  output logic                       portb_data_bus_oe_o,
  // Mail flags
  output logic                       a_to_b_mail_full_n_o,
  output logic                       b_to_a_mail_full_n_o,
  // FIFO path
  input  wire logic [DPM_DATA_W-1:0] fifo_out_data_i,
  output logic                       fifo_write_o,
  output logic                       fifo_read_o
);

  // ********************************************************
  // Port clock edge detection
  // ********************************************************
  logic                  pa_clk_reg;
  logic                  pb_clk_reg;
  logic                  pa_rise;
  logic                  pb_rise;
  logic                  pa_go;
  logic                  pb_go;
  logic                  pa_mail_wr;
  logic                  pa_mail_rd;
  logic                  pb_mail_wr;
  logic                  pb_mail_rd;
  logic                  a2b_wr_ok;
  logic                  b2a_wr_ok;
  logic [DPM_DATA_W-1:0] a_to_b_mailbox_reg;
  logic [DPM_DATA_W-1:0] b_to_a_mailbox_reg;
  logic                  a2b_full_n_reg;
  logic                  b2a_full_n_reg;

  // Previous level of each port clock; inputs are already synchronous
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pa_clk_reg <= DPM_CLK_Q_RST;
      pb_clk_reg <= DPM_CLK_Q_RST;
    end else begin
      pa_clk_reg <= porta_clock_i;
      pb_clk_reg <= portb_clock_i;
    end
  end

  // History resets high, so a port clock resting high at release gives no edge
  assign pa_rise = porta_clock_i & ~pa_clk_reg;
  assign pb_rise = portb_clock_i & ~pb_clk_reg;

  // ********************************************************
  // Transfer decode per port
  // ********************************************************
  // Write bit high means write on both ports, whatever the pin polarity
  // Selected transfer: chip select low and enable high on a port edge
  assign pa_go      = pa_rise & ~porta_ctrl_i.chip_select_n & porta_ctrl_i.enable;
  assign pb_go      = pb_rise & ~portb_ctrl_i.chip_select_n & portb_ctrl_i.enable;
  assign pa_mail_wr = pa_go & porta_ctrl_i.write & porta_ctrl_i.mail_select;   // R3
  assign pa_mail_rd = pa_go & ~porta_ctrl_i.write & porta_ctrl_i.mail_select;  // R10
  assign pb_mail_wr = pb_go & portb_ctrl_i.write & portb_ctrl_i.mail_select;   // R4
  assign pb_mail_rd = pb_go & ~portb_ctrl_i.write & portb_ctrl_i.mail_select;  // R9
  // Full flag low blocks a new write
  assign a2b_wr_ok  = pa_mail_wr & a2b_full_n_reg;  // R6
  assign b2a_wr_ok  = pb_mail_wr & b2a_full_n_reg;  // R6

  // FIFO path strobes when mail select is low
  assign fifo_write_o = pa_go & porta_ctrl_i.write & ~porta_ctrl_i.mail_select;  // R2
  assign fifo_read_o  = pb_go & ~portb_ctrl_i.write & ~portb_ctrl_i.mail_select; // R2

  // ********************************************************
  // Mailbox storage
  // ********************************************************
  // A-to-B word loads only on an accepted port A write; reads leave it intact
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_to_b_mailbox_reg <= DPM_MAIL_RST;
    end else if (a2b_wr_ok) begin
      a_to_b_mailbox_reg <= porta_data_bus_i;  // R1 R3 R11
    end
  end

  // B-to-A word loads only on an accepted port B write; reads leave it intact
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      b_to_a_mailbox_reg <= DPM_MAIL_RST;
    end else if (b2a_wr_ok) begin
      b_to_a_mailbox_reg <= portb_data_bus_i;  // R1 R4 R11
    end
  end

  // ********************************************************
  // Mail full flags
  // ********************************************************
  // A-to-B flag: port A write clears, port B read sets; a write in the same
  // cycle as a read wins, so fresh mail is never lost. One clock, no crossing.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a2b_full_n_reg <= DPM_FULL_N_RST;  // R13
    end else if (a2b_wr_ok) begin
      a2b_full_n_reg <= 1'h0;  // R5 R14
    end else if (pb_mail_rd) begin
      a2b_full_n_reg <= 1'h1;  // R9 R14
    end
  end

  // B-to-A flag: mirror image, port B writes and port A reads
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      b2a_full_n_reg <= DPM_FULL_N_RST;  // R13
    end else if (b2a_wr_ok) begin
      b2a_full_n_reg <= 1'h0;  // R5 R14
    end else if (pa_mail_rd) begin
      b2a_full_n_reg <= 1'h1;  // R10 R14
    end
  end

  assign a_to_b_mail_full_n_o = a2b_full_n_reg;
  assign b_to_a_mail_full_n_o = b2a_full_n_reg;

  // ********************************************************
  // Data bus drivers
  // ********************************************************
  // Bus drives whenever the port is selected for reading, edge or not
  assign porta_data_bus_oe_o = ~porta_ctrl_i.chip_select_n & ~porta_ctrl_i.write;
  assign portb_data_bus_oe_o = ~portb_ctrl_i.chip_select_n & ~portb_ctrl_i.write;
  // Port A has no FIFO source, so its bus only ever shows mail
  assign porta_data_bus_o    = b_to_a_mailbox_reg;  // R8
  assign portb_data_bus_o    = portb_ctrl_i.mail_select ? a_to_b_mailbox_reg
                                                        : fifo_out_data_i;  // R7

  // ********************************************************
  // Assertions
  // ********************************************************
  // All checks run on clk_i; port clocks are plain sampled inputs here
  default clocking dpm_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a2b_store_a: assert property (a2b_wr_ok |=> a_to_b_mailbox_reg == $past(porta_data_bus_i)) // R3
    else $error("A-to-B mailbox did not store port A word");
  b2a_store_a: assert property (b2a_wr_ok |=> b_to_a_mailbox_reg == $past(portb_data_bus_i)) // R4
    else $error("B-to-A mailbox did not store port B word");
  mail_flag_low_a: assert property ((a2b_wr_ok || b2a_wr_ok) |=> // R5
                                    (!a_to_b_mail_full_n_o || !$past(a2b_wr_ok))
                                    && (!b_to_a_mail_full_n_o || !$past(b2a_wr_ok)))
    else $error("Accepted write did not drop mail flag");
  full_block_a: assert property ((pa_mail_wr && !a_to_b_mail_full_n_o) |=> $stable(a_to_b_mailbox_reg)) // R6
    else $error("Write to full A-to-B mailbox changed it");
  portb_mux_a: assert property (portb_data_bus_oe_o |-> // R7
                                portb_data_bus_o == (portb_ctrl_i.mail_select ? a_to_b_mailbox_reg
                                                                              : fifo_out_data_i))
    else $error("Port B output source wrong");
  porta_mux_a: assert property (porta_data_bus_oe_o |-> porta_data_bus_o == b_to_a_mailbox_reg) // R8
    else $error("Port A output not B-to-A mailbox");
  a2b_read_a: assert property ((pb_mail_rd && !a2b_wr_ok) |=> a_to_b_mail_full_n_o) // R9
    else $error("Port B mail read did not free A-to-B flag");
  b2a_read_a: assert property ((pa_mail_rd && !b2a_wr_ok) |=> b_to_a_mail_full_n_o) // R10
    else $error("Port A mail read did not free B-to-A flag");
  mail_hold_a: assert property (!a2b_wr_ok ##1 !a2b_wr_ok |-> $stable(a_to_b_mailbox_reg)) // R11
    else $error("A-to-B mailbox changed without a write");
  flag_hold_a: assert property ((!b2a_wr_ok && !pa_mail_rd) |=> $stable(b_to_a_mail_full_n_o)) // R14
    else $error("B-to-A flag moved without cause");

  // Mirror checks for the second mailbox and the FIFO steering
  b2a_full_block_a: assert property ((pb_mail_wr && !b_to_a_mail_full_n_o) |=> $stable(b_to_a_mailbox_reg)) // R6
    else $error("Write to full B-to-A mailbox changed it");
  b2a_hold_a: assert property (!b2a_wr_ok ##1 !b2a_wr_ok |-> $stable(b_to_a_mailbox_reg)) // R11
    else $error("B-to-A mailbox changed without a write");
  a2b_flag_hold_a: assert property ((!a2b_wr_ok && !pb_mail_rd) |=> $stable(a_to_b_mail_full_n_o)) // R14
    else $error("A-to-B flag moved without cause");
  fifo_wr_steer_a: assert property (fifo_write_o |=> $stable(a_to_b_mailbox_reg)) // R2
    else $error("FIFO write touched the A-to-B mailbox");
  fifo_rd_steer_a: assert property ((fifo_read_o && !a2b_wr_ok) |=> $stable(a_to_b_mail_full_n_o)) // R2
    else $error("FIFO read moved the A-to-B flag");

  // Reset must leave both boxes empty; watched while reset is held
  reset_empty_a: assert property (@(posedge clk_i) disable iff (1'h0)
                                  (rst_i ##1 rst_i) |-> (a_to_b_mail_full_n_o && b_to_a_mail_full_n_o)) // R13
    else $error("Mail flag low during reset");

  // Main scenarios: round trips, refused writes, write meeting read
  a2b_round_c: cover property (a2b_wr_ok ##[1:20] pb_mail_rd);
  b2a_round_c: cover property (b2a_wr_ok ##[1:20] pa_mail_rd);
  write_full_c: cover property (pa_mail_wr && !a_to_b_mail_full_n_o);
  same_cycle_c: cover property (a2b_wr_ok && pb_mail_rd);
  b2a_full_c: cover property (pb_mail_wr && !b_to_a_mail_full_n_o);

endmodule : dpm_mailbox

//--- dpm_port_model.sv
// Bus master model for one mailbox port: port clock plus one transfer per call.
// Assumes clk_i is the block's system clock; the port clock rests low between transfers.
`timescale 1ns/1ps
module dpm_port_model
  import dpm_pkg::*;
#(
  // Depth expansion: mailboxes unusable, so mail select is forced low
  parameter bit CHAINED = 1'h0
)
(
  // System
  input  wire logic                  clk_i,
  // Port pins
  output logic                       port_clock_o,
  output dpm_port_ctrl_type          ctrl_o,
  output logic      [DPM_DATA_W-1:0] data_o
);
  // Idle, deselected port at time zero
  initial begin
    port_clock_o = 1'h0;
    ctrl_o       = '{1'h1, 1'h0, 1'h0, 1'h0};
    data_o       = '0;
  end
  // ********************************************************
  // Transfer: low phase, high phase with controls, low again
  // ********************************************************
  task automatic xfer(input logic w, input logic m, input logic e, input logic [DPM_DATA_W-1:0] d);
    @(posedge clk_i);
    #1 port_clock_o = 1'h0;
    @(posedge clk_i);
    #1 port_clock_o = 1'h1;
    ctrl_o = '{1'h0, w, e, m & ~CHAINED};
    data_o = d;
    @(posedge clk_i);
    #1 port_clock_o = 1'h0;
    ctrl_o.chip_select_n = 1'h1;  // Mail select kept for the output mux
    data_o = ~d;  // Released bus never shows the stale word
  endtask : xfer
endmodule : dpm_port_model

//--- dual_port_mailbox_tb.sv
// Self-checking bench for dpm_mailbox with a queue-based reference model.
// Assumes dpm_port_model drives both ports; random traffic from a fixed LFSR seed.
`timescale 1ns/1ps
module dual_port_mailbox_tb;
  import dpm_pkg::*;
  logic                  clk_i, rst_i, pa_clk, pb_clk, pa_oe, pb_oe, fa_n, fb_n, f_wr, f_rd;
  logic                  p, w, m, e, mb;
  dpm_port_ctrl_type     pa_ctrl, pb_ctrl;
  logic [DPM_DATA_W-1:0] pa_din, pb_din, pa_dout, pb_dout, f_data, a2b, b2a, d;
  logic [DPM_DATA_W-1:0] ab_q[$], ba_q[$];  // Pending mail per direction, never deeper than one
  logic [15:0]           lfsr_q;
  int                    err_count, n_tests, nwr, nrd, nwr_seen = 0, nrd_seen = 0;
  dpm_port_model i_pa (.clk_i(clk_i), .port_clock_o(pa_clk), .ctrl_o(pa_ctrl), .data_o(pa_din));
  dpm_port_model i_pb (.clk_i(clk_i), .port_clock_o(pb_clk), .ctrl_o(pb_ctrl), .data_o(pb_din));
  dpm_mailbox i_dut (.clk_i(clk_i), .rst_i(rst_i), .porta_clock_i(pa_clk), .porta_ctrl_i(pa_ctrl),
    .porta_data_bus_i(pa_din), .porta_data_bus_o(pa_dout), .porta_data_bus_oe_o(pa_oe),
    .portb_clock_i(pb_clk), .portb_ctrl_i(pb_ctrl), .portb_data_bus_i(pb_din),
    .portb_data_bus_o(pb_dout), .portb_data_bus_oe_o(pb_oe), .a_to_b_mail_full_n_o(fa_n),
    .b_to_a_mail_full_n_o(fb_n), .fifo_out_data_i(f_data), .fifo_write_o(f_wr), .fifo_read_o(f_rd));
  // ********************************************************
  // Clock, strobe counters, helpers
  // ********************************************************
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // Strobes stand one cycle, so count them on every edge
  always @(posedge clk_i) begin
    nwr_seen <= nwr_seen + int'(f_wr);
    nrd_seen <= nrd_seen + int'(f_rd);
  end
  task automatic check(input logic [DPM_DATA_W-1:0] seen, input logic [DPM_DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [DPM_DATA_W-1:0] next_rand();
    logic [DPM_DATA_W-1:0] v;
    v = '0;
    repeat (3) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      v      = {v[19:0], lfsr_q};
    end
    return v;
  endfunction : next_rand
  // Reset pulse; the model forgets pending mail, port selects stay as driven
  task automatic do_reset(input int cycles);
    rst_i = 1'h1;
    repeat (cycles) @(posedge clk_i);
    #1 rst_i = 1'h0;
    a2b = DPM_MAIL_RST;
    b2a = DPM_MAIL_RST;
    ab_q.delete();
    ba_q.delete();
    check(fa_n, 1'h1);
    check(fb_n, 1'h1);
    check(pa_dout, DPM_MAIL_RST);
  endtask : do_reset
  // Enables looked at mid-cycle; a port drives only while selected for a read
  always @(negedge clk_i) begin
    if (rst_i === 1'h0) begin
      check(pa_oe, !pa_ctrl.chip_select_n && !pa_ctrl.write);
      check(pb_oe, !pb_ctrl.chip_select_n && !pb_ctrl.write);
      if (pa_oe === 1'h1) check(pa_dout, b2a);
      if (pb_oe === 1'h1) check(pb_dout, pb_ctrl.mail_select ? a2b : f_data);
    end
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100000;
    err_count++;
    results();
  end
  // ********************************************************
  // Reset, then random traffic against the reference model
  // ********************************************************
  initial begin
    err_count = 0;
    n_tests   = 0;
    nwr       = 0;
    nrd       = 0;
    lfsr_q    = 16'ha827;
    f_data    = '0;
    mb        = 1'h0;  // Port B model starts with mail select low
    do_reset(12);
    for (int i = 0; i < 80; i++) begin
      if (i == 40) do_reset(2);  // Mid-run reset must drop pending mail
      f_data = next_rand();
      d      = next_rand();
      {p, w, m, e} = {f_data[0], f_data[1], |f_data[3:2], |f_data[5:4]};
      if (p) i_pb.xfer(w, m, e, d);
      else i_pa.xfer(w, m, e, d);
      // Write takes only an empty box; a read frees it and leaves the word
      if (e && !p && w && m && ab_q.size() == 0) begin
        a2b = d;
        ab_q.push_back(d);
      end
      if (e && p && w && m && ba_q.size() == 0) begin
        b2a = d;
        ba_q.push_back(d);
      end
      if (e && !p && !w && m && ba_q.size() != 0) check(pa_dout, ba_q.pop_front());
      if (e && p && !w && m && ab_q.size() != 0) check(pb_dout, ab_q.pop_front());
      if (e && !p && w && !m) nwr++;
      if (e && p && !w && !m) nrd++;
      if (p) mb = m;
      check(fa_n, 1'(ab_q.size() == 0));
      check(fb_n, 1'(ba_q.size() == 0));
      check(pa_dout, b2a);
      check(pb_dout, mb ? a2b : f_data);
      check(DPM_DATA_W'(nwr_seen), DPM_DATA_W'(nwr));
      check(DPM_DATA_W'(nrd_seen), DPM_DATA_W'(nrd));
    end
    results();
  end
endmodule : dual_port_mailbox_tb
